// *** rtl/twb_cfg.svh ***
// Constants for the tag block write sequencer.
// Assumes inclusion by bare name from the sequencer and its package users.
//
// Contract
// - Command code 0x05 selects and starts the data block write sequence.
// - Start block is an absolute block index from 0, not a byte address.
// - Selector bit 7 set means key B, clear means key A.
// - Six-byte key is least significant byte first.
// - With a key supplied, authenticate the starting block's sector before writing.
// - Failed authentication loads its error code and ends without writing.
// - After authentication write the start block, then following blocks until count exhausted.
// - Skip key and lock-bit blocks; skipped blocks do not count.
// - Entering a new sector, authenticate it with the same key before writing.
// - Buffer bytes are taken consecutively from the offset across all blocks.
// - All blocks written successfully sets the result to no-error.
// - A failed block write stores a write error code in the result.
`ifndef TWB_CFG_SVH
`define TWB_CFG_SVH

// ----------------------------------------
// Command and argument layout
// ----------------------------------------
`define TWB_CMD_WRITE_BLOCK 8'h05
`define TWB_KEYSEL_B_BIT 7
`define TWB_KEYSEL_KEY_BIT 6

// ----------------------------------------
// Tag memory geometry
// ----------------------------------------
`define TWB_BLOCK_BYTES 5'h10
`define TWB_LAST_BYTE 5'h0f
`define TWB_LAST_BLOCK 8'hff

// ----------------------------------------
// Result codes
// ----------------------------------------
`define TWB_RES_NO_ERR 8'h00
`define TWB_RES_AUTH_ERR 8'h01
`define TWB_RES_WRITE_ERR 8'h02
`define TWB_RES_PARAM_ERR 8'h03
`define TWB_RES_CMD_ERR 8'h04

// ----------------------------------------
// Defaults
// ----------------------------------------
`define TWB_BUF_LEN 256
`define TWB_FIFO_DEPTH 4

`endif

// *** rtl/twb_pkg.sv ***
// Types shared by the tag block write sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package twb_pkg;

	// ----------------------------------------
	// Sequencer states and tag operations
	// ----------------------------------------
	typedef enum logic [2:0] {
		TWB_IDLE,
		TWB_SEEK,
		TWB_AUTH_REQ,
		TWB_AUTH_WAIT,
		TWB_WR_REQ,
		TWB_FILL,
		TWB_WR_WAIT
	} twb_state_t;

	typedef enum logic {
		TWB_OP_AUTH,
		TWB_OP_WRITE
	} twb_op_t;

	// ----------------------------------------
	// Sequencer state record
	// ----------------------------------------
	typedef struct packed {
		twb_state_t st;
		logic [7:0] blk;
		logic [7:0] cnt;
		logic [7:0] ptr;
		logic key_on;
		logic key_b;
		logic [47:0] key;
		logic [5:0] sect;
		logic sect_ok;
		logic [4:0] byte_cnt;
		logic rd_pend;
		logic [7:0] result;
		logic res_vld;
	} twb_seq_t;

endpackage
`default_nettype wire

// *** rtl/twb_fifo.sv ***
// Small FIFO holding block bytes on their way to the tag link.
// Assumes one clock, synchronous active-low reset and a shared clock enable.
`timescale 1ns/10ps
`default_nettype none
module twb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] cnt;
	} twb_fifo_st_t;

	twb_fifo_st_t s_ff;
	twb_fifo_st_t nxt_s;
	logic push;
	logic pop;

	// Handshakes closed while frozen so nothing is lost
	assign in_ready = clk_en && (s_ff.cnt != CW'(DEPTH));
	assign out_valid = clk_en && (s_ff.cnt != '0);
	assign out_data = s_ff.mem[s_ff.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		nxt_s = s_ff;
		if (push) begin
			nxt_s.mem[s_ff.wp] = in_data;
			nxt_s.wp = (s_ff.wp == PW'(DEPTH - 1)) ? '0 : s_ff.wp + PW'(1);
		end
		if (pop) begin
			nxt_s.rp = (s_ff.rp == PW'(DEPTH - 1)) ? '0 : s_ff.rp + PW'(1);
		end
		if (push && !pop) begin
			nxt_s.cnt = s_ff.cnt + CW'(1);
		end else if (pop && !push) begin
			nxt_s.cnt = s_ff.cnt - CW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_ff <= '0;
		end else if (clk_en) begin
			s_ff <= nxt_s;
		end
	end

	fifo_count_a: assert property (@(posedge clk) disable iff (!rst_b)
		s_ff.cnt <= CW'(DEPTH)) else $error("fifo count above depth");
endmodule
`default_nettype wire

// *** rtl/twb_write_seq.sv ***
// Write data block command sequencer: authenticates sectors and streams
// buffer bytes into consecutive data blocks of the tag.
// Assumes a synchronous data buffer with one cycle read latency and a tag
// link that answers each request with one response pulse.
`timescale 1ns/10ps
`default_nettype none
`include "twb_cfg.svh"
module twb_write_seq #(
	parameter int BUF_LEN = `TWB_BUF_LEN,
	parameter int FIFO_DEPTH = `TWB_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_arg_block,
	input wire logic [7:0] cmd_arg_count,
	input wire logic [7:0] cmd_arg_offset,
	input wire logic [7:0] cmd_arg_key_sel,
	input wire logic [47:0] cmd_arg_key,
	output logic buf_rd_en,
	output logic [7:0] buf_rd_addr,
	input wire logic [7:0] buf_rd_data,
	output logic tag_req_valid,
	input wire logic tag_req_ready,
	output logic tag_req_write,
	output logic [7:0] tag_req_block,
	output logic tag_req_key_b,
	output logic [47:0] tag_req_key,
	output logic tag_data_valid,
	input wire logic tag_data_ready,
	output logic [7:0] tag_data,
	input wire logic tag_resp_valid,
	input wire logic tag_resp_ok,
	output logic busy,
	output logic result_valid,
	output logic [7:0] result_code
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	twb_pkg::twb_seq_t s_ff;
	twb_pkg::twb_seq_t nxt_s;
	logic fifo_in_ready;
	logic fifo_push;
	logic cmd_take;
	logic [12:0] total_end;
	logic args_bad;
	logic resp_take;

	// Sector index: 32 small sectors of 4 blocks, then 16-block sectors
	function automatic logic [5:0] sector_of(input logic [7:0] blk);
		sector_of = blk[7] ? {3'b100, blk[6:4]} : {1'b0, blk[6:2]};
	endfunction

	// Last block of each sector holds keys and lock bits
	function automatic logic is_trailer(input logic [7:0] blk);
		is_trailer = blk[7] ? (&blk[3:0]) : (&blk[1:0]);
	endfunction

	// ----------------------------------------
	// Handshakes and outputs
	// ----------------------------------------
	assign cmd_ready = clk_en && (s_ff.st == twb_pkg::TWB_IDLE);
	assign cmd_take = cmd_valid && cmd_ready;
	assign resp_take = clk_en && tag_resp_valid;
	assign tag_req_valid = clk_en && ((s_ff.st == twb_pkg::TWB_AUTH_REQ) || (s_ff.st == twb_pkg::TWB_WR_REQ));
	assign tag_req_write = (s_ff.st == twb_pkg::TWB_WR_REQ);
	assign tag_req_block = s_ff.blk;
	assign tag_req_key_b = s_ff.key_b;
	assign tag_req_key = s_ff.key;
	assign buf_rd_en = (s_ff.st == twb_pkg::TWB_FILL) && !s_ff.rd_pend && fifo_in_ready;
	assign buf_rd_addr = s_ff.ptr;
	assign fifo_push = clk_en && (s_ff.st == twb_pkg::TWB_FILL) && s_ff.rd_pend;
	assign busy = (s_ff.st != twb_pkg::TWB_IDLE);
	assign result_valid = s_ff.res_vld;
	assign result_code = s_ff.result;

	// reject a span that runs past the buffer
	assign total_end = {1'b0, cmd_arg_count, 4'h0} + {5'h00, cmd_arg_offset};
	assign args_bad = (cmd_arg_count == 8'h00) || (total_end > 13'(BUF_LEN));

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		nxt_s = s_ff;
		nxt_s.res_vld = 1'b0;
		case (s_ff.st)
			twb_pkg::TWB_IDLE: begin
				if (cmd_take) begin
					// only the block write code runs
					if (cmd_code != `TWB_CMD_WRITE_BLOCK) begin
						nxt_s.result = `TWB_RES_CMD_ERR;
						nxt_s.res_vld = 1'b1;
					end else if (args_bad) begin
						nxt_s.result = `TWB_RES_PARAM_ERR;
						nxt_s.res_vld = 1'b1;
					end else begin
						nxt_s.blk = cmd_arg_block;
						nxt_s.cnt = cmd_arg_count;
						nxt_s.ptr = cmd_arg_offset;
						nxt_s.key_b = cmd_arg_key_sel[`TWB_KEYSEL_B_BIT];
						nxt_s.key_on = cmd_arg_key_sel[`TWB_KEYSEL_KEY_BIT];
						nxt_s.key = cmd_arg_key;
						nxt_s.sect_ok = 1'b0;
						nxt_s.st = twb_pkg::TWB_SEEK;
					end
				end
			end
			twb_pkg::TWB_SEEK: begin
				if (is_trailer(s_ff.blk)) begin
					if (s_ff.blk == `TWB_LAST_BLOCK) begin
						nxt_s.result = `TWB_RES_PARAM_ERR;
						nxt_s.res_vld = 1'b1;
						nxt_s.st = twb_pkg::TWB_IDLE;
					end else begin
						nxt_s.blk = s_ff.blk + 8'h01;
					end
				end else if (s_ff.key_on && (!s_ff.sect_ok || (sector_of(s_ff.blk) != s_ff.sect))) begin
					nxt_s.sect = sector_of(s_ff.blk);
					nxt_s.sect_ok = 1'b0;
					nxt_s.st = twb_pkg::TWB_AUTH_REQ;
				end else begin
					nxt_s.st = twb_pkg::TWB_WR_REQ;
				end
			end
			twb_pkg::TWB_AUTH_REQ: begin
				if (tag_req_ready) begin
					nxt_s.st = twb_pkg::TWB_AUTH_WAIT;
				end
			end
			twb_pkg::TWB_AUTH_WAIT: begin
				if (resp_take) begin
					if (tag_resp_ok) begin
						nxt_s.sect_ok = 1'b1;
						nxt_s.st = twb_pkg::TWB_WR_REQ;
					end else begin
						nxt_s.result = `TWB_RES_AUTH_ERR;
						nxt_s.res_vld = 1'b1;
						nxt_s.st = twb_pkg::TWB_IDLE;
					end
				end
			end
			twb_pkg::TWB_WR_REQ: begin
				if (tag_req_ready) begin
					nxt_s.byte_cnt = 5'h00;
					nxt_s.rd_pend = 1'b0;
					nxt_s.st = twb_pkg::TWB_FILL;
				end
			end
			twb_pkg::TWB_FILL: begin
				if (s_ff.rd_pend) begin
					nxt_s.rd_pend = 1'b0;
					nxt_s.ptr = s_ff.ptr + 8'h01;
					nxt_s.byte_cnt = s_ff.byte_cnt + 5'h01;
					if (s_ff.byte_cnt == `TWB_LAST_BYTE) begin
						nxt_s.st = twb_pkg::TWB_WR_WAIT;
					end
				end else if (fifo_in_ready) begin
					nxt_s.rd_pend = 1'b1;
				end
			end
			twb_pkg::TWB_WR_WAIT: begin
				if (resp_take) begin
					if (!tag_resp_ok) begin
						nxt_s.result = `TWB_RES_WRITE_ERR;
						nxt_s.res_vld = 1'b1;
						nxt_s.st = twb_pkg::TWB_IDLE;
					end else if (s_ff.cnt == 8'h01) begin
						nxt_s.cnt = 8'h00;
						nxt_s.result = `TWB_RES_NO_ERR;
						nxt_s.res_vld = 1'b1;
						nxt_s.st = twb_pkg::TWB_IDLE;
					end else if (s_ff.blk == `TWB_LAST_BLOCK) begin
						nxt_s.result = `TWB_RES_PARAM_ERR;
						nxt_s.res_vld = 1'b1;
						nxt_s.st = twb_pkg::TWB_IDLE;
					end else begin
						nxt_s.cnt = s_ff.cnt - 8'h01;
						nxt_s.blk = s_ff.blk + 8'h01;
						nxt_s.st = twb_pkg::TWB_SEEK;
					end
				end
			end
			default: begin
				nxt_s.st = twb_pkg::TWB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_ff <= '0;
		end else if (clk_en) begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------
	// Byte buffer toward the tag
	// ----------------------------------------
	twb_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(buf_rd_data),
		.out_valid(tag_data_valid),
		.out_ready(tag_data_ready),
		.out_data(tag_data)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	wrong_code_a: assert property (cmd_take && (cmd_code != `TWB_CMD_WRITE_BLOCK)
		|=> result_valid && (result_code == `TWB_RES_CMD_ERR) && !busy) else $error("foreign code not refused");
	start_block_a: assert property (cmd_take && (cmd_code == `TWB_CMD_WRITE_BLOCK) && !args_bad
		|=> busy && (s_ff.blk == $past(cmd_arg_block)) && (s_ff.cnt == $past(cmd_arg_count))) else $error("start block lost");
	key_type_a: assert property (cmd_take && (cmd_code == `TWB_CMD_WRITE_BLOCK) && !args_bad
		|=> (tag_req_key_b == $past(cmd_arg_key_sel[7])) && (tag_req_key == $past(cmd_arg_key))) else $error("key type wrong");
	auth_before_a: assert property (tag_req_valid && tag_req_write && s_ff.key_on
		|-> s_ff.sect_ok && (s_ff.sect == sector_of(tag_req_block))) else $error("write before auth");
	auth_fail_a: assert property (clk_en && (s_ff.st == twb_pkg::TWB_AUTH_WAIT) && tag_resp_valid && !tag_resp_ok
		|=> result_valid && (result_code == `TWB_RES_AUTH_ERR) && !busy ##1 !tag_req_valid) else $error("auth failure kept going");
	count_step_a: assert property (clk_en && (s_ff.st == twb_pkg::TWB_WR_WAIT) && tag_resp_valid && tag_resp_ok
		&& (s_ff.cnt > 8'h01) && (s_ff.blk != 8'hff)
		|=> (s_ff.cnt == $past(s_ff.cnt) - 8'h01) && (s_ff.blk == $past(s_ff.blk) + 8'h01)) else $error("count not stepped");
	trailer_skip_a: assert property (tag_req_valid |-> !is_trailer(tag_req_block)) else $error("trailer block requested");
	// buffer pointer advances by one per byte
	ptr_step_a: assert property (fifo_push |=> buf_rd_addr == $past(buf_rd_addr) + 8'h01) else $error("buffer pointer skipped");
	no_error_a: assert property (clk_en && (s_ff.st == twb_pkg::TWB_WR_WAIT) && tag_resp_valid && tag_resp_ok
		&& (s_ff.cnt == 8'h01) |=> result_valid && (result_code == `TWB_RES_NO_ERR)) else $error("success not reported");
	write_fail_a: assert property (clk_en && (s_ff.st == twb_pkg::TWB_WR_WAIT) && tag_resp_valid && !tag_resp_ok
		|=> result_valid && (result_code == `TWB_RES_WRITE_ERR)) else $error("write failure not reported");
	block_bytes_a: assert property (fifo_push && (s_ff.byte_cnt == 5'h0f)
		|=> (s_ff.st == twb_pkg::TWB_WR_WAIT) && (s_ff.byte_cnt == 5'h10)) else $error("block byte count wrong");

	auth_seen_c: cover property (clk_en && (s_ff.st == twb_pkg::TWB_AUTH_WAIT) && tag_resp_valid && tag_resp_ok);
	trailer_seen_c: cover property ((s_ff.st == twb_pkg::TWB_SEEK) && is_trailer(s_ff.blk));
	done_ok_c: cover property (result_valid && (result_code == `TWB_RES_NO_ERR));
	reauth_c: cover property (clk_en && (s_ff.st == twb_pkg::TWB_AUTH_REQ) && s_ff.sect_ok == 1'b0 && s_ff.cnt != cmd_arg_count);
endmodule
`default_nettype wire

// *** test/twb_tag_model.sv ***
// Tag link partner: takes requests, sinks block bytes, answers each request.
// Assumes requests change just after rising edges of clk.
`timescale 1ns/10ps
`default_nettype none
module twb_tag_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic slow,
	input wire logic [7:0] fail_at,
	input wire logic tag_req_valid,
	output logic tag_req_ready,
	input wire logic tag_req_write,
	input wire logic [7:0] tag_req_block,
	input wire logic tag_req_key_b,
	input wire logic [47:0] tag_req_key,
	input wire logic tag_data_valid,
	output logic tag_data_ready,
	input wire logic [7:0] tag_data,
	output logic tag_resp_valid,
	output logic tag_resp_ok
);
	logic [57:0] req_q[$];
	logic [7:0] byte_q[$];
	logic busy = 1'b0;
	logic wr = 1'b0;
	int nreq = 0;
	int got = 0;
	int dly = 0;
	int cyc = 0;

	task automatic clear();
		req_q.delete();
		byte_q.delete();
		nreq = 0;
	endtask

	initial begin
		tag_req_ready = 1'b0;
		tag_data_ready = 1'b0;
		tag_resp_valid = 1'b0;
		tag_resp_ok = 1'b0;
	end

	// ----------------------------------------
	// Request and byte capture
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_b) begin
			busy = 1'b0;
		end else begin
			if (tag_req_valid && tag_req_ready) begin
				req_q.push_back({tag_req_write, tag_req_key_b, tag_req_key, tag_req_block});
				nreq++;
				busy = 1'b1;
				wr = tag_req_write;
				got = 0;
				dly = slow ? 5 : 0;
			end
			if (tag_data_valid && tag_data_ready) begin
				byte_q.push_back(tag_data);
				got++;
			end
		end
	end

	// ----------------------------------------
	// Handshakes and answers
	// ----------------------------------------
	always @(negedge clk) begin
		cyc++;
		tag_req_ready <= !busy && (!slow || cyc % 4 == 0);
		tag_data_ready <= busy && wr && got < 16 && (!slow || cyc % 3 != 0);
		if (busy && (!wr || got == 16) && dly == 0) begin
			tag_resp_valid <= 1'b1;
			tag_resp_ok <= (nreq != int'(fail_at));
			busy = 1'b0;
		end else begin
			tag_resp_valid <= 1'b0;
			tag_resp_ok <= ~tag_resp_ok;
			if (busy && (!wr || got == 16))
				dly--;
		end
	end
endmodule
`default_nettype wire

// *** test/tag_block_write_command_tb.sv ***
// Bench for the tag block write sequencer: corner and random commands,
// expected tag traffic worked out from the block geometry.
// Assumes the design files and the tag link model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "twb_cfg.svh"
module tag_block_write_command_tb;
	logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, cmd_valid = 1'b0, slow = 1'b0;
	logic cmd_ready, buf_rd_en, busy, result_valid, tag_req_valid, tag_req_ready, tag_req_write;
	logic tag_req_key_b, tag_data_valid, tag_data_ready, tag_resp_valid, tag_resp_ok;
	logic [7:0] cmd_code = 8'h00, cmd_arg_block = 8'h00, cmd_arg_count = 8'h00, cmd_arg_offset = 8'h00;
	logic [7:0] cmd_arg_key_sel = 8'h00, buf_rd_data = 8'h00, fail_at = 8'h00;
	logic [7:0] buf_rd_addr, tag_req_block, tag_data, result_code;
	logic [47:0] cmd_arg_key = 48'h0, tag_req_key;
	logic [7:0] mem[256];
	logic [57:0] exp_q[$];
	logic [31:0] seed = 32'h00006fda;
	int fail_count = 0;
	int compares = 0;

	twb_write_seq u_twb_write_seq (.clk, .rst_b, .clk_en, .cmd_valid, .cmd_ready, .cmd_code, .cmd_arg_block,
		.cmd_arg_count, .cmd_arg_offset, .cmd_arg_key_sel, .cmd_arg_key, .buf_rd_en, .buf_rd_addr, .buf_rd_data,
		.tag_req_valid, .tag_req_ready, .tag_req_write, .tag_req_block, .tag_req_key_b, .tag_req_key,
		.tag_data_valid, .tag_data_ready, .tag_data, .tag_resp_valid, .tag_resp_ok, .busy, .result_valid,
		.result_code);
	twb_tag_model u_twb_tag_model (.clk, .rst_b, .slow, .fail_at, .tag_req_valid, .tag_req_ready,
		.tag_req_write, .tag_req_block, .tag_req_key_b, .tag_req_key, .tag_data_valid, .tag_data_ready,
		.tag_data, .tag_resp_valid, .tag_resp_ok);

	initial begin
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
		if (buf_rd_en)
			buf_rd_data <= mem[buf_rd_addr];

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic bit trailer(input logic [7:0] b);
		return b < 8'h80 ? b[1:0] == 2'h3 : b[3:0] == 4'hf;
	endfunction

	function automatic logic [6:0] sector(input logic [7:0] b);
		return b < 8'h80 ? 7'(b >> 2) : 7'(8'h20 + ((b - 8'h80) >> 4));
	endfunction

	function automatic logic [7:0] expect_cmd(input logic [7:0] code, blk, cnt, off, ksel,
		input logic [47:0] key, input int fail);
		logic [7:0] b;
		logic [6:0] cur;
		exp_q.delete();
		if (code !== `TWB_CMD_WRITE_BLOCK)
			return `TWB_RES_CMD_ERR;
		if (cnt == 8'h00 || int'(off) + 16 * int'(cnt) > 256)
			return `TWB_RES_PARAM_ERR;
		b = blk;
		cur = 7'h7f;
		for (int i = 0; i < int'(cnt); i++) begin
			while (trailer(b))
				b++;
			if (ksel[6] && sector(b) != cur) begin
				cur = sector(b);
				exp_q.push_back({1'b0, ksel[7], key, b});
				if (exp_q.size() == fail)
					return `TWB_RES_AUTH_ERR;
			end
			exp_q.push_back({1'b1, ksel[7], key, b});
			if (exp_q.size() == fail)
				return `TWB_RES_WRITE_ERR;
			b++;
		end
		return `TWB_RES_NO_ERR;
	endfunction

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// One command, checked against the geometry
	// ----------------------------------------
	task automatic run(input logic [7:0] code, blk, cnt, off, ksel, input logic [47:0] key, input int fail,
		input bit slw);
		logic [7:0] er;
		logic [57:0] m;
		int n;
		int nw;
		er = expect_cmd(code, blk, cnt, off, ksel, key, fail);
		u_twb_tag_model.clear();
		fail_at = 8'(fail);
		slow = slw;
		{cmd_code, cmd_arg_block, cmd_arg_count, cmd_arg_offset, cmd_arg_key_sel} = {code, blk, cnt, off, ksel};
		cmd_arg_key = key;
		cmd_valid = 1'b1;
		check("cmd_ready", 1, cmd_ready);
		@(negedge clk);
		cmd_valid = 1'b0;
		{cmd_code, cmd_arg_block, cmd_arg_count, cmd_arg_offset} = ~{code, blk, cnt, off};
		cmd_arg_key = ~key;
		for (n = 0; n < 4000 && result_valid !== 1'b1; n++) begin
			if (busy === 1'b1)
				check("cmd_ready busy", 0, cmd_ready);
			@(negedge clk);
		end
		check("result", er, result_code);
		check("busy", 0, busy);
		if (er == `TWB_RES_CMD_ERR || er == `TWB_RES_PARAM_ERR)
			check("latency", 0, n);
		@(negedge clk);
		check("result_valid", 0, result_valid);
		check("requests", exp_q.size(), u_twb_tag_model.req_q.size());
		nw = 0;
		for (int i = 0; i < exp_q.size() && i < u_twb_tag_model.req_q.size(); i++) begin
			m = exp_q[i][57] ? {1'b1, 49'h0, 8'hff} : ~58'h0;
			nw += exp_q[i][57];
			check("request", exp_q[i] & m, u_twb_tag_model.req_q[i] & m);
		end
		check("bytes", 16 * nw, u_twb_tag_model.byte_q.size());
		for (int k = 0; k < u_twb_tag_model.byte_q.size(); k++)
			check("byte", mem[8'(int'(off) + k)], u_twb_tag_model.byte_q[k]);
		$display("test done code %h block %h count %h result %h", code, blk, cnt, result_code);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] codes[5] = '{8'h00, 8'h04, 8'h06, 8'h07, 8'hff};
		foreach (mem[i])
			mem[i] = 8'(rnd());
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		run(8'h05, 8'h01, 8'h01, 8'h00, 8'h40, 48'h665544332211, 0, 0);
		run(8'h05, 8'h00, 8'h03, 8'h10, 8'h00, 48'h0, 0, 1);
		run(8'h05, 8'h03, 8'h02, 8'h05, 8'hc0, 48'ha1b2c3d4e5f6, 0, 0);
		run(8'h05, 8'h7c, 8'h05, 8'he0 - 8'h40, 8'h40, 48'h123456789abc, 0, 1);
		run(8'h05, 8'h08, 8'h03, 8'h00, 8'h41, 48'h1, 1, 0);
		run(8'h05, 8'h0a, 8'h04, 8'h20, 8'hc0, 48'h2, 4, 1);
		run(8'h05, 8'h04, 8'h00, 8'h00, 8'h40, 48'h3, 0, 0);
		run(8'h05, 8'h04, 8'h02, 8'he1, 8'h40, 48'h4, 0, 0);
		run(8'h05, 8'h8e, 8'h02, 8'he0, 8'h40, 48'h5, 0, 0);
		foreach (codes[i])
			run(codes[i], 8'h01, 8'h01, 8'h00, 8'h40, 48'h6, 0, 0);
		repeat (24)
			run(8'h05, 8'(rnd() % 200), 8'(1 + rnd() % 8), 8'(rnd()) & 8'h7f, 8'(rnd()),
				48'({rnd(), rnd()}), int'(rnd() % 6), rnd() % 2);
		conclude();
	end

	initial begin
		repeat (80000) @(posedge clk);
		fail_count++;
		conclude();
	end
endmodule
`default_nettype wire
